// ### raster_pkg.sv
// Purpose: Shared constants and types of the raster-op pixel write path
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes: Offsets below form the software-visible register map

package raster_pkg;

   // ********************************************
   // Register map
   // ********************************************
   localparam int REG_ADDR_W = 8;
   localparam logic [7:0] OFF_ROP_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_BCOLOR_BASE = 8'h20;
   localparam logic [7:0] OFF_BCOLOR_LAST = 8'h3C;
   localparam int NUM_BCOLOR = 8;

   // ********************************************
   // Raster operation control fields
   // ********************************************
   localparam logic [31:0] ROP_CTRL_RESET = 32'h0000_0003;
   localparam logic [31:0] ROP_CTRL_MASK = 32'h0000_0F0F;
   localparam int ROP_LSB = 0;
   localparam int BITMAP_LSB = 8;
   localparam int BYTE_LSB = 10;

   localparam logic [3:0] ROP_ZERO = 4'h0;
   localparam logic [3:0] ROP_SRC = 4'h3;
   localparam logic [3:0] ROP_NOT_SRC = 4'hC;
   localparam logic [3:0] ROP_ONE = 4'hF;

   localparam logic [1:0] BM_8_PACKED = 2'h0;
   localparam logic [1:0] BM_8_UNPACKED = 2'h1;
   localparam logic [1:0] BM_12 = 2'h2;
   localparam logic [1:0] BM_24 = 2'h3;

   // Status register bits
   localparam int ST_PEND = 0;
   localparam int ST_STAGED = 1;
   localparam int ST_BUSY = 2;

   typedef enum logic [1:0]
   {
      MODE_NORMAL,
      MODE_BLOCK_FILL,
      MODE_BLOCK_STIPPLE,
      MODE_DMA_WR_COPY
   } draw_mode_t;

endpackage

// ### rop_if.sv
// Purpose: Carries operands and result between write path and ROP unit
// Assumes: Same clock on both sides, purely combinational path
// Notes: None

`timescale 1ns/1ns

interface rop_if;
   logic [3:0] code;
   logic [31:0] src;
   logic [31:0] dest;
   logic [31:0] result;

   modport path
   (
      output code,
      output src,
      output dest,
      input result
   );

   modport unit
   (
      input code,
      input src,
      input dest,
      output result
   );
endinterface

// ### rop_unit.sv
// Purpose: Boolean combination of source and destination pixel words
// Assumes: Code already forced to copy by the caller where needed
// Notes: Purely combinational

`timescale 1ns/1ns

module rop_unit
   import raster_pkg::*;
(
   rop_if.unit bus
);

   // ********************************************
   // Sixteen two-operand functions
   // ********************************************
   function automatic logic [31:0] combine(input logic [3:0] c,
                                           input logic [31:0] s,
                                           input logic [31:0] d);
      case (c)
         4'h0: combine = 32'h0000_0000;
         4'h1: combine = s & d;
         4'h2: combine = s & ~d;
         4'h3: combine = s;
         4'h4: combine = ~s & d;
         4'h5: combine = d;
         4'h6: combine = s ^ d;
         4'h7: combine = s | d;
         4'h8: combine = ~s & ~d;
         4'h9: combine = ~s ^ d;
         4'hA: combine = ~d;
         4'hB: combine = s | ~d;
         4'hC: combine = ~s;
         4'hD: combine = ~s | d;
         4'hE: combine = ~s | ~d;
         default: combine = 32'hFFFF_FFFF;
      endcase
   endfunction

   always_comb
   begin
      bus.result = combine(bus.code, bus.src, bus.dest);
   end

endmodule

// ### raster_op_block_color.sv
// Purpose: Pixel write path with raster ops and block-color pattern
// Assumes: Memory takes a write in one cycle; reads answer later
// Notes: One-entry write buffer drains before a control write lands
//
// What this block does
// - Byte field picks destination byte lane for eight-bit unpacked bitmaps
// - Bitmap field names destination pixel format
// - Raster field selects source/destination combining function
// - Codes zero to seven fixed functions
// - Codes eight to fifteen fixed functions
// - Block and DMA-write modes always copy source
// - Destination read first only in normal mode, dest-using codes
// - Control write waits for write buffer drain
// - Control register resets to plain copy
// - Pattern is colors seven down to zero
// - Eight-bit block patterns carry four copies
// - Deep bitmaps use all eight colors
// - Eight-bit bitmaps use colors one, zero
// - Plane mask applies to block writes

`timescale 1ns/1ns

module raster_op_block_color
   import raster_pkg::*;
#(
   parameter int MEM_ADDR_W = 24
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [REG_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic pix_valid,
   output logic pix_ready,
   input wire draw_mode_t pix_mode,
   input wire logic [MEM_ADDR_W-1:0] pix_addr,
   input wire logic [31:0] pix_src,
   input wire logic [31:0] plane_mask,
   output logic mem_rd_req,
   input wire logic mem_rd_valid,
   input wire logic [31:0] mem_rd_data,
   output logic mem_wr_req,
   output logic mem_block,
   output logic [MEM_ADDR_W-1:0] mem_addr,
   output logic [31:0] mem_wr_data,
   output logic [3:0] mem_byte_en,
   output logic [31:0] mem_plane_mask,
   output logic [255:0] block_pattern
);

   typedef enum
   {
      ST_IDLE,
      ST_WAIT_DEST,
      ST_WRITE
   } wr_state_t;

   // ********************************************
   // Decode helpers
   // ********************************************
   function automatic logic is_bcolor(input logic [REG_ADDR_W-1:0] a);
      is_bcolor = (a >= OFF_BCOLOR_BASE) && (a <= OFF_BCOLOR_LAST)
                  && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [2:0] bcolor_idx(input logic [REG_ADDR_W-1:0] a);
      logic [REG_ADDR_W-1:0] off;
      off = a - OFF_BCOLOR_BASE;
      bcolor_idx = off[4:2];
   endfunction

   // Block and DMA-write modes bypass the programmed code
   function automatic logic forced_copy(input draw_mode_t m);
      forced_copy = (m != MODE_NORMAL);
   endfunction

   // Codes that never look at the destination skip the read
   function automatic logic needs_dest(input logic [3:0] c);
      needs_dest = !(c == ROP_ZERO || c == ROP_SRC
                     || c == ROP_NOT_SRC || c == ROP_ONE);
   endfunction

   // ********************************************
   // Register state
   // ********************************************
   logic [31:0] rop_ctrl;
   logic [31:0] next_rop_ctrl;
   logic [31:0] staged_ctrl;
   logic [31:0] next_staged_ctrl;
   logic staged;
   logic next_staged;
   logic [31:0] bcolor [NUM_BCOLOR];
   logic [31:0] next_bcolor [NUM_BCOLOR];
   logic [31:0] next_reg_rdata;
   logic [255:0] next_block_pattern;

   // ********************************************
   // Write path state
   // ********************************************
   wr_state_t state;
   wr_state_t next_state;
   logic pend;
   logic next_pend;
   draw_mode_t pend_mode;
   draw_mode_t next_pend_mode;
   logic [MEM_ADDR_W-1:0] pend_addr;
   logic [MEM_ADDR_W-1:0] next_pend_addr;
   logic [31:0] pend_src;
   logic [31:0] next_pend_src;
   logic [31:0] dest_word;
   logic [31:0] next_dest_word;
   logic next_mem_rd_req;
   logic next_mem_wr_req;
   logic next_mem_block;
   logic [MEM_ADDR_W-1:0] next_mem_addr;
   logic [31:0] next_mem_wr_data;
   logic [3:0] next_mem_byte_en;
   logic [31:0] next_mem_plane_mask;

   logic [3:0] rop_code;
   logic [1:0] bitmap_type;
   logic [1:0] byte_sel;
   logic [3:0] eff_code;
   logic take_pixel;

   rop_if rop_bus ();

   rop_unit u_rop
   (
      .bus(rop_bus)
   );

   assign rop_code = rop_ctrl[ROP_LSB +: 4];
   assign bitmap_type = rop_ctrl[BITMAP_LSB +: 2];
   assign byte_sel = rop_ctrl[BYTE_LSB +: 2];
   assign eff_code = forced_copy(pend_mode) ? ROP_SRC : rop_code;

   // buffer refuses new pixels while control write waits
   assign pix_ready = !pend && !staged;
   assign take_pixel = pix_valid && pix_ready;

   assign rop_bus.code = eff_code;
   assign rop_bus.src = pend_src;
   assign rop_bus.dest = dest_word;

   // ********************************************
   // Register port
   // ********************************************
   always_comb
   begin
      next_rop_ctrl = rop_ctrl;
      next_staged_ctrl = staged_ctrl;
      next_staged = staged;
      next_bcolor = bcolor;
      next_reg_rdata = 32'h0000_0000;
      if (reg_wr && reg_addr == OFF_ROP_CTRL)
      begin
         next_staged_ctrl = reg_wdata & ROP_CTRL_MASK;
         next_staged = 1'b1;
      end
      else if (reg_wr && is_bcolor(reg_addr))
      begin
         next_bcolor[bcolor_idx(reg_addr)] = reg_wdata;
      end
      // new value lands only once buffer and path are empty
      if (staged && !pend && state == ST_IDLE)
      begin
         next_rop_ctrl = staged_ctrl;
         next_staged = next_staged && reg_wr && reg_addr == OFF_ROP_CTRL;
      end
      if (reg_rd)
      begin
         if (reg_addr == OFF_ROP_CTRL)
         begin
            next_reg_rdata = rop_ctrl & ROP_CTRL_MASK;
         end
         else if (reg_addr == OFF_STATUS)
         begin
            next_reg_rdata[ST_PEND] = pend;
            next_reg_rdata[ST_STAGED] = staged;
            next_reg_rdata[ST_BUSY] = (state != ST_IDLE);
         end
         else if (is_bcolor(reg_addr))
         begin
            next_reg_rdata = bcolor[bcolor_idx(reg_addr)];
         end
      end
      next_block_pattern = {bcolor[7], bcolor[6], bcolor[5], bcolor[4],
                            bcolor[3], bcolor[2], bcolor[1], bcolor[0]};
      if (bitmap_type == BM_8_PACKED || bitmap_type == BM_8_UNPACKED)
      begin
         // two words, four copies make 32 pixels
         next_block_pattern = {4{bcolor[1], bcolor[0]}};
      end
   end

   // color words carry no reset value
   always_ff @(posedge clk)
   begin
      bcolor <= next_bcolor;
      block_pattern <= next_block_pattern;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rop_ctrl <= ROP_CTRL_RESET;
         staged_ctrl <= ROP_CTRL_RESET;
         staged <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end
      else
      begin
         rop_ctrl <= next_rop_ctrl;
         staged_ctrl <= next_staged_ctrl;
         staged <= next_staged;
         reg_rdata <= next_reg_rdata;
      end
   end

   // ********************************************
   // Pixel write sequence
   // ********************************************
   always_comb
   begin
      next_state = state;
      next_pend = pend;
      next_pend_mode = pend_mode;
      next_pend_addr = pend_addr;
      next_pend_src = pend_src;
      next_dest_word = dest_word;
      next_mem_rd_req = 1'b0;
      next_mem_wr_req = 1'b0;
      next_mem_block = 1'b0;
      next_mem_addr = mem_addr;
      next_mem_wr_data = mem_wr_data;
      next_mem_byte_en = mem_byte_en;
      next_mem_plane_mask = mem_plane_mask;
      if (take_pixel)
      begin
         next_pend = 1'b1;
         next_pend_mode = pix_mode;
         next_pend_addr = pix_addr;
         next_pend_src = pix_src;
      end
      case (state)
         ST_IDLE:
         begin
            if (pend)
            begin
               if (pend_mode != MODE_DMA_WR_COPY && needs_dest(eff_code))
               begin
                  next_mem_rd_req = 1'b1;
                  next_mem_addr = pend_addr;
                  next_state = ST_WAIT_DEST;
               end
               else
               begin
                  next_dest_word = 32'h0000_0000;
                  next_state = ST_WRITE;
               end
            end
         end
         ST_WAIT_DEST:
         begin
            if (mem_rd_valid)
            begin
               next_dest_word = mem_rd_data;
               next_state = ST_WRITE;
            end
         end
         ST_WRITE:
         begin
            next_mem_wr_req = 1'b1;
            next_mem_addr = pend_addr;
            next_mem_wr_data = rop_bus.result;
            next_mem_block = (pend_mode == MODE_BLOCK_FILL)
                             || (pend_mode == MODE_BLOCK_STIPPLE);
            next_mem_plane_mask = plane_mask;
            next_mem_byte_en = 4'hF;
            if (bitmap_type == BM_8_UNPACKED)
            begin
               next_mem_byte_en = 4'(4'h1 << byte_sel);
            end
            next_pend = 1'b0;
            next_state = ST_IDLE;
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         pend <= 1'b0;
         pend_mode <= MODE_NORMAL;
         pend_addr <= '0;
         pend_src <= 32'h0000_0000;
         dest_word <= 32'h0000_0000;
         mem_rd_req <= 1'b0;
         mem_wr_req <= 1'b0;
         mem_block <= 1'b0;
         mem_addr <= '0;
         mem_wr_data <= 32'h0000_0000;
         mem_byte_en <= 4'h0;
         mem_plane_mask <= 32'h0000_0000;
      end
      else
      begin
         state <= next_state;
         pend <= next_pend;
         pend_mode <= next_pend_mode;
         pend_addr <= next_pend_addr;
         pend_src <= next_pend_src;
         dest_word <= next_dest_word;
         mem_rd_req <= next_mem_rd_req;
         mem_wr_req <= next_mem_wr_req;
         mem_block <= next_mem_block;
         mem_addr <= next_mem_addr;
         mem_wr_data <= next_mem_wr_data;
         mem_byte_en <= next_mem_byte_en;
         mem_plane_mask <= next_mem_plane_mask;
      end
   end

endmodule

// ### rop_chk.sv
// Purpose: Port-level checks of the raster-op write path
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound from the testbench top file

`timescale 1ns/1ns

module rop_chk
   import raster_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [REG_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic pix_valid,
   input wire logic pix_ready,
   input wire draw_mode_t pix_mode,
   input wire logic [31:0] plane_mask,
   input wire logic mem_rd_req,
   input wire logic mem_rd_valid,
   input wire logic mem_wr_req,
   input wire logic mem_block,
   input wire logic [31:0] mem_plane_mask
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // ********************************************
   // Sequences
   // ********************************************
   sequence s_take;
      pix_valid && pix_ready;
   endsequence

   sequence s_ctrl_rd;
      reg_rd && !reg_wr && reg_addr == OFF_ROP_CTRL;
   endsequence

   // ********************************************
   // Properties
   // ********************************************
   property p_reset_val;
      $past(rst) ##0 s_ctrl_rd |=> reg_rdata == ROP_CTRL_RESET;
   endproperty
   a_reset_val: assert property (p_reset_val)
      else $error("control not at reset value");

   property p_resv;
      s_ctrl_rd |=> (reg_rdata & ~ROP_CTRL_MASK) == 32'h0;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved control bits nonzero");

   property p_blk;
      s_take ##0 (pix_mode == MODE_BLOCK_FILL ||
         pix_mode == MODE_BLOCK_STIPPLE) |-> ##[1:4] (mem_wr_req && mem_block);
   endproperty
   a_blk: assert property (p_blk)
      else $error("no block write after block request");

   property p_no_rd;
      s_take ##0 pix_mode != MODE_NORMAL |=> !mem_rd_req [*4];
   endproperty
   a_no_rd: assert property (p_no_rd)
      else $error("destination read in copy-only mode");

   property p_rmw;
      mem_rd_valid |-> ##[1:3] mem_wr_req;
   endproperty
   a_rmw: assert property (p_rmw)
      else $error("no write after destination read");

   property p_stage;
      reg_wr && reg_addr == OFF_ROP_CTRL |=> !pix_ready;
   endproperty
   a_stage: assert property (p_stage)
      else $error("pixel accepted while control staged");

   property p_pulse;
      mem_wr_req |=> !mem_wr_req;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("memory write longer than one cycle");

   property p_mask;
      mem_wr_req |-> mem_plane_mask == plane_mask;
   endproperty
   a_mask: assert property (p_mask)
      else $error("plane mask not carried to write");
endmodule

// ### vmem_model.sv
// Purpose: Video memory stand-in answering destination reads
// Assumes: One read outstanding, latency set by the bench
// Notes: Stale read data is inverted every cycle

`timescale 1ns/1ns

module vmem_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic mem_rd_req,
   input wire logic [23:0] mem_addr,
   input wire logic [3:0] lat,
   output logic mem_rd_valid,
   output logic [31:0] mem_rd_data
);
   logic [3:0] cnt;
   logic [23:0] a;
   logic busy;

   always @(posedge clk)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= 32'h0;
      end
      else if (mem_rd_req)
      begin
         busy <= 1'b1;
         cnt <= lat;
         a <= mem_addr;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= ~mem_rd_data;
      end
      else if (busy && cnt < 4'h2)
      begin
         busy <= 1'b0;
         mem_rd_valid <= 1'b1;
         mem_rd_data <= ~{8'h00, a};
      end
      else
      begin
         mem_rd_valid <= 1'b0;
         // Stale data must never look valid
         mem_rd_data <= ~mem_rd_data;
         if (busy)
            cnt <= cnt - 4'h1;
      end
   end
endmodule

// ### raster_op_block_color_test.sv
// Purpose: Self-checking bench of the raster-op write path
// Assumes: Memory model answers reads after lat cycles
// Notes: Seeded random operands, fixed corner cases

`timescale 1ns/1ns

module raster_op_block_color_test
   import raster_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic pix_valid = 1'b0;
   logic pix_ready;
   draw_mode_t pix_mode = MODE_NORMAL;
   logic [23:0] pix_addr = 24'h0;
   logic [31:0] pix_src = 32'h0;
   logic [31:0] plane_mask = 32'h0;
   logic mem_rd_req, mem_rd_valid, mem_wr_req, mem_block;
   logic [23:0] mem_addr;
   logic [31:0] mem_rd_data, mem_wr_data, mem_plane_mask;
   logic [3:0] mem_byte_en;
   logic [255:0] block_pattern, pat;
   logic [3:0] lat = 4'h1;
   logic [1:0] bm, by;
   logic [31:0] k, rv, c;
   logic [23:0] adr = 24'h0;
   int error_cnt = 0;
   int check_count = 0;

   raster_op_block_color dut
   (
      .clk(clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .pix_valid(pix_valid),
      .pix_ready(pix_ready),
      .pix_mode(pix_mode),
      .pix_addr(pix_addr),
      .pix_src(pix_src),
      .plane_mask(plane_mask),
      .mem_rd_req(mem_rd_req),
      .mem_rd_valid(mem_rd_valid),
      .mem_rd_data(mem_rd_data),
      .mem_wr_req(mem_wr_req),
      .mem_block(mem_block),
      .mem_addr(mem_addr),
      .mem_wr_data(mem_wr_data),
      .mem_byte_en(mem_byte_en),
      .mem_plane_mask(mem_plane_mask),
      .block_pattern(block_pattern)
   );

   vmem_model vm
   (
      .clk(clk),
      .rst(rst),
      .mem_rd_req(mem_rd_req),
      .mem_addr(mem_addr),
      .lat(lat),
      .mem_rd_valid(mem_rd_valid),
      .mem_rd_data(mem_rd_data)
   );

   always #20 clk = ~clk;

   // ********************************************
   // Helpers
   // ********************************************
   task chk(input logic [255:0] got, input logic [255:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   function automatic logic [31:0] rop(input logic [3:0] c,
      input logic [31:0] s, input logic [31:0] d);
      logic [31:0] r;
      for (int i = 0; i < 32; i++)
         r[i] = c[{~s[i], ~d[i]}];
      return r;
   endfunction

   task pix(input draw_mode_t m, input logic [31:0] k);
      int n;
      logic rs;
      logic [31:0] s, pm, e;
      adr = adr + 24'h1;
      s = $urandom;
      pm = $urandom;
      n = 0;
      rs = 1'b0;
      @(posedge clk);
      pix_valid <= 1'b1;
      pix_mode <= m;
      pix_src <= s;
      pix_addr <= adr;
      plane_mask <= pm;
      #1;
      while (pix_ready !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      pix_valid <= 1'b0;
      #1;
      chk(pix_ready, 1'b0);
      while (mem_wr_req !== 1'b1 && n < 80)
      begin
         @(posedge clk);
         #1;
         n++;
         if (mem_rd_req === 1'b1)
            rs = 1'b1;
      end
      e = (m == MODE_NORMAL) ? rop(k[3:0], s, ~{8'h00, adr}) : s;
      chk(mem_wr_req, 1'b1);
      chk(rs, m == MODE_NORMAL && !(k[3:0] inside
         {ROP_ZERO, ROP_SRC, ROP_NOT_SRC, ROP_ONE}));
      chk(mem_wr_data, e);
      chk(mem_block, m inside {MODE_BLOCK_FILL, MODE_BLOCK_STIPPLE});
      chk(mem_addr, adr);
      chk(mem_byte_en, (k[9:8] == BM_8_UNPACKED) ?
         4'h1 << k[11:10] : 4'hF);
      chk(mem_plane_mask, pm);
   endtask

   task test_done;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ********************************************
   // Tests
   // ********************************************
   initial
   begin
      void'($urandom(97));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, ROP_CTRL_RESET);
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, rv);
      chk(rv, 32'h0);
      wr(OFF_ROP_CTRL, 32'hFFFF_F5F6);
      rd(OFF_ROP_CTRL, rv);
      chk(rv, 32'h0000_0506);
      $display("register test done");
      for (int i = 0; i < 16; i++)
      begin
         bm = 2'($urandom_range(3));
         by = (bm == BM_8_UNPACKED) ? 2'($urandom_range(3)) : 2'h0;
         lat = 4'($urandom_range(6, 1));
         k = {20'h0, by, bm, 4'h0, 4'(i)};
         wr(OFF_ROP_CTRL, k);
         pix(MODE_NORMAL, k);
      end
      $display("raster code test done");
      for (int m = 1; m < 4; m++)
      begin
         k = {22'h0, BM_24, 4'h0, 4'($urandom)};
         wr(OFF_ROP_CTRL, k);
         pix(draw_mode_t'(m), k);
      end
      $display("mode test done");
      wr(OFF_ROP_CTRL, 32'h0000_0303);
      for (int i = 0; i < 8; i++)
      begin
         c = {8'h00, 24'($urandom)};
         pat = {c, pat[255:32]};
         wr(OFF_BCOLOR_BASE + 8'(4 * i), c);
      end
      rd(OFF_BCOLOR_LAST, rv);
      chk(rv, pat[255:224]);
      repeat (3) @(posedge clk);
      chk(block_pattern, pat);
      wr(OFF_ROP_CTRL, 32'h0000_0103);
      wr(OFF_BCOLOR_BASE, {4{8'h3C}});
      wr(OFF_BCOLOR_BASE + 8'h04, {4{8'hA7}});
      repeat (3) @(posedge clk);
      chk(block_pattern, {4{{4{8'hA7}}, {4{8'h3C}}}});
      $display("pattern test done");
      wr(OFF_ROP_CTRL, 32'h0000_0106);
      lat <= 4'h8;
      fork
         pix(MODE_NORMAL, 32'h0000_0106);
         begin
            repeat (4) @(posedge clk);
            wr(OFF_ROP_CTRL, 32'h0000_030A);
            rd(OFF_STATUS, rv);
            chk(rv[ST_STAGED], 1'b1);
            chk(rv[ST_PEND], 1'b1);
            chk(rv[ST_BUSY], 1'b1);
            rd(OFF_ROP_CTRL, rv);
            chk(rv, 32'h0000_0106);
         end
      join
      repeat (2) @(posedge clk);
      rd(OFF_ROP_CTRL, rv);
      chk(rv, 32'h0000_030A);
      $display("drain test done");
      test_done;
   end

   initial
   begin
      #(40 * 5000);
      error_cnt++;
      $display("BAD %0t watchdog", $time);
      test_done;
   end
endmodule

bind raster_op_block_color rop_chk chk
(
   .clk(clk),
   .rst(rst),
   .reg_addr(reg_addr),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .pix_valid(pix_valid),
   .pix_ready(pix_ready),
   .pix_mode(pix_mode),
   .plane_mask(plane_mask),
   .mem_rd_req(mem_rd_req),
   .mem_rd_valid(mem_rd_valid),
   .mem_wr_req(mem_wr_req),
   .mem_block(mem_block),
   .mem_plane_mask(mem_plane_mask)
);
